/* rtl/csb_pkg.sv */
/*
 * csb_pkg: constants and carriers for the core special-function register bank.
 * assumes: one clock, synchronous active-high reset, byte-wide direct sfr bus from the core.
 */
package csb_pkg;

	// ************************************************************
	// sfr direct addresses
	// ************************************************************
	localparam logic [7:0] ADDR_STACK_POINTER_LOW      = 8'h81;
	localparam logic [7:0] ADDR_DATA_POINTER_LOW       = 8'h82;
	localparam logic [7:0] ADDR_DATA_POINTER_HIGH      = 8'h83;
	localparam logic [7:0] ADDR_PROGRAM_CONTROL        = 8'h87;
	localparam logic [7:0] ADDR_CORE_CONFIGURATION     = 8'haf;
	localparam logic [7:0] ADDR_STACK_POINTER_HIGH     = 8'hb7;
	localparam logic [7:0] ADDR_STACK_BOUNDARY_CONTROL = 8'hbf;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int POS_DOUBLE_BAUD     = 7;
	localparam int POS_SPH_RESERVED    = 7;
	localparam int POS_STACK_BOTTOM    = 6;
	localparam int POS_SSA_HI          = 5;
	localparam int POS_SSA_LO          = 3;
	localparam int POS_SP_HI           = 2;
	localparam int POS_WTRL_HI         = 7;
	localparam int POS_WTRL_LO         = 3;
	localparam int POS_VIOLATION_RESET = 2;
	localparam int POS_PROTECT_ENABLE  = 1;
	localparam int POS_WATERLINE_FLAG  = 0;
	localparam int POS_CFG_RESERVED    = 7;
	localparam int POS_SERIAL_ENH      = 6;
	localparam int POS_SERIAL_SELECT   = 5;
	localparam int POS_MOD_ENABLE      = 4;
	localparam int POS_XRAM_HI         = 1;
	localparam int POS_XRAM_LO         = 0;

	// ************************************************************
	// reset values and the stack top
	// ************************************************************
	localparam logic [7:0]  RST_PROGRAM_CONTROL = 8'h00;
	localparam logic [7:0]  RST_DATA_POINTER    = 8'h00;
	localparam logic [7:0]  RST_STACK_LOW       = 8'h00;
	localparam logic [2:0]  RST_STACK_START     = 3'h1;
	localparam logic [2:0]  RST_STACK_HIGH      = 3'h1;
	localparam logic [4:0]  RST_WATERLINE       = 5'h00;
	localparam logic [1:0]  RST_XRAM_ENABLE     = 2'h1;
	localparam logic [10:0] WATERLINE_TOP       = 11'h7ff;
	localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
	localparam logic [7:0]  RST_OPCODE          = 8'h00;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csb_sfr_req_s;

	typedef struct packed {
		logic        double_baud_select;
		logic        serial_enhancement_enable;
		logic        shared_serial_port_select;
		logic        modulation_enable;
		logic        external_move_enable;
		logic [15:0] data_pointer_full;
		logic [10:0] stack_pointer;
	} csb_ctrl_s;

	typedef struct packed {
		logic       load;
		logic [1:0] len;
		logic       jump;
		logic [15:0] target;
		logic [7:0] opcode;
	} csb_instr_s;

endpackage : csb_pkg

/* rtl/csb_pc_unit.sv */
/*
 * csb_pc_unit: program counter and opcode holding register of the core.
 * assumes: the core's sequencer pulses load at the end of each instruction with its length or a jump target.
 */
`timescale 1ns/1ps
module csb_pc_unit
	import csb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire csb_instr_s  instr_i,
	output logic [15:0]      program_counter_o,
	output logic [7:0]       opcode_o
);

	// ************************************************************
	// program counter, hidden from the sfr bus
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			program_counter_o <= RST_PROGRAM_COUNTER;
		end else if (instr_i.load && instr_i.jump) begin
			program_counter_o <= instr_i.target;
		end else if (instr_i.load) begin
			program_counter_o <= program_counter_o + {14'h0000, instr_i.len};
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			opcode_o <= RST_OPCODE;
		end else if (instr_i.load) begin
			opcode_o <= instr_i.opcode;
		end
	end

endmodule : csb_pc_unit

/* rtl/csb_sfr_bank.sv */
/*
 * csb_sfr_bank: core special-function register bank with stack boundary protection.
 * assumes: the core drives one sfr request per cycle; read data are registered, one cycle after rd.
 * assumes: the violation pulses last one cycle; whoever turns stack_reset_o into a device reset
 *          must stretch it, and the watchdog vector logic must latch stack_irq_o.
 * limitation: the waterline flag has no reset, so it is unknown until first set or cleared.
 */
`timescale 1ns/1ps
module csb_sfr_bank
	import csb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire csb_sfr_req_s sfr_req_i,
	input  wire logic        stack_push_i,
	input  wire logic        stack_pop_i,
	input  wire logic        data_pointer_full_load_i,
	input  wire logic [15:0] data_pointer_full_value_i,
	input  wire csb_instr_s  instr_i,
	output logic [7:0]       sfr_rdata_o,
	output logic             sfr_hit_o,
	output csb_ctrl_s        ctrl_o,
	output logic             stack_irq_o,
	output logic             stack_reset_o,
	output logic [15:0]      program_counter_o,
	output logic [7:0]       opcode_o
);

	// ************************************************************
	// state
	// ************************************************************
	logic        double_baud_r;
	logic [6:0]  program_control_low_r;
	logic [7:0]  dpl_r;
	logic [7:0]  dph_r;
	logic [7:0]  spl_r;
	logic [2:0]  sph_r;
	logic [2:0]  ssa_r;
	logic        sph_top_r;
	logic        bottom_flag_r;
	logic [4:0]  waterline_r;
	logic        viol_reset_r;
	logic        protect_r;
	logic        wtrl_flag_r;
	logic        cfg_top_r;
	logic        ser_enh_r;
	logic        ser_sel_r;
	logic        mod_en_r;
	logic [1:0]  cfg_rsv_r;
	logic [1:0]  xram_r;
	logic [7:0]  rdata_r;
	logic        wtrl_seen_r;

	logic [10:0] sp_full;
	logic [10:0] sp_nxt;
	logic        sp_change;
	logic [10:0] waterline_addr;
	logic        above_wtrl;
	logic        bottom_viol;
	logic        wtrl_event;
	logic        wtrl_clear;
	logic [10:0] stack_floor;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic wr_at(input csb_sfr_req_s r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction : wr_at

	function automatic logic is_mapped(input logic [7:0] a);
		return a inside {ADDR_STACK_POINTER_LOW, ADDR_DATA_POINTER_LOW, ADDR_DATA_POINTER_HIGH,
			ADDR_PROGRAM_CONTROL, ADDR_CORE_CONFIGURATION, ADDR_STACK_POINTER_HIGH,
			ADDR_STACK_BOUNDARY_CONTROL};
	endfunction : is_mapped

	// the start field names only the top three bits; the base below them is zero
	function automatic logic [10:0] stack_base(input logic [2:0] s);
		return {s, 8'h00};
	endfunction : stack_base

	// ************************************************************
	// stack pointer next value
	// ************************************************************
	// the live pointer is the two stored halves side by side
	assign sp_full     = {sph_r, spl_r};
	assign stack_floor = stack_base(ssa_r);

	// priority: low byte write, high byte write, push, pop
	always_comb begin
		sp_nxt    = sp_full;
		sp_change = 1'b0;
		if (wr_at(sfr_req_i, ADDR_STACK_POINTER_LOW)) begin
			sp_nxt    = {sph_r, sfr_req_i.wdata};
			sp_change = 1'b1;
		end else if (wr_at(sfr_req_i, ADDR_STACK_POINTER_HIGH)) begin
			sp_nxt    = {sfr_req_i.wdata[POS_SP_HI:0], spl_r};
			sp_change = 1'b1;
		end else if (stack_push_i) begin
			// overflow past the top rolls to the programmed start, not to zero
			sp_nxt    = (sp_full == WATERLINE_TOP) ? stack_floor : sp_full + 11'h001;
			sp_change = 1'b1;
		end else if (stack_pop_i) begin
			sp_nxt    = sp_full - 11'h001;
			sp_change = 1'b1;
		end
	end

	// a move below the start is caught before it lands, so the old pointer survives
	assign bottom_viol    = protect_r && sp_change && (sp_nxt < stack_floor);
	assign waterline_addr = WATERLINE_TOP - {6'h00, waterline_r};
	// strictly greater: a pointer sitting on the line is still legal
	assign above_wtrl     = (waterline_r != 5'h00) && (sp_full > waterline_addr);
	assign wtrl_event     = protect_r && above_wtrl && !wtrl_seen_r;
	// a clear attempted while still above the line is ignored, so the cause is not lost
	assign wtrl_clear     = wr_at(sfr_req_i, ADDR_STACK_BOUNDARY_CONTROL) && !sfr_req_i.wdata[POS_WATERLINE_FLAG]
		&& !above_wtrl;

	// ************************************************************
	// register writes
	// ************************************************************
	// reserved low bits are stored, so a read shows what software left there
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			double_baud_r <= RST_PROGRAM_CONTROL[POS_DOUBLE_BAUD];
			program_control_low_r    <= RST_PROGRAM_CONTROL[6:0];
		end else if (wr_at(sfr_req_i, ADDR_PROGRAM_CONTROL)) begin
			double_baud_r <= sfr_req_i.wdata[POS_DOUBLE_BAUD];
			program_control_low_r    <= sfr_req_i.wdata[6:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dpl_r <= RST_DATA_POINTER;
			dph_r <= RST_DATA_POINTER;
		end else begin
			// a byte write in the same cycle as a whole-pointer load wins for its byte
			if (data_pointer_full_load_i) begin
				{dph_r, dpl_r} <= data_pointer_full_value_i;
			end
			if (wr_at(sfr_req_i, ADDR_DATA_POINTER_LOW)) begin
				dpl_r <= sfr_req_i.wdata;
			end
			if (wr_at(sfr_req_i, ADDR_DATA_POINTER_HIGH)) begin
				dph_r <= sfr_req_i.wdata;
			end
		end
	end

	// a dropped move leaves both halves untouched
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			spl_r <= RST_STACK_LOW;
			sph_r <= RST_STACK_HIGH;
		end else if (sp_change && !bottom_viol) begin
			spl_r <= sp_nxt[7:0];
			sph_r <= sp_nxt[10:8];
		end
	end

	// the start moves with every stack-high write, even one whose pointer part is dropped
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ssa_r     <= RST_STACK_START;
			sph_top_r <= 1'b1;
		end else if (wr_at(sfr_req_i, ADDR_STACK_POINTER_HIGH)) begin
			ssa_r     <= sfr_req_i.wdata[POS_SSA_HI:POS_SSA_LO];
			sph_top_r <= sfr_req_i.wdata[POS_SPH_RESERVED];
		end
	end

	// set wins over the software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bottom_flag_r <= 1'b0;
		end else if (bottom_viol) begin
			bottom_flag_r <= 1'b1;
		end else if (wr_at(sfr_req_i, ADDR_STACK_POINTER_HIGH) && !sfr_req_i.wdata[POS_STACK_BOTTOM]) begin
			bottom_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			waterline_r  <= RST_WATERLINE;
			viol_reset_r <= 1'b0;
			protect_r    <= 1'b0;
		end else if (wr_at(sfr_req_i, ADDR_STACK_BOUNDARY_CONTROL)) begin
			waterline_r  <= sfr_req_i.wdata[POS_WTRL_HI:POS_WTRL_LO];
			viol_reset_r <= sfr_req_i.wdata[POS_VIOLATION_RESET];
			protect_r    <= sfr_req_i.wdata[POS_PROTECT_ENABLE];
		end
	end

	// the flag survives reset; cleared only by software while under the line
	always_ff @(posedge clk_i) begin
		if (wtrl_event) begin
			wtrl_flag_r <= 1'b1;
		end else if (wtrl_clear) begin
			wtrl_flag_r <= 1'b0;
		end
	end

	// one event per excursion above the line, rearmed once the pointer drops back
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wtrl_seen_r <= 1'b0;
		end else begin
			wtrl_seen_r <= protect_r && above_wtrl;
		end
	end

	// reserved fields are stored, not forced; keeping them legal is software's job
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_top_r <= 1'b1;
			ser_enh_r <= 1'b0;
			ser_sel_r <= 1'b0;
			mod_en_r  <= 1'b0;
			cfg_rsv_r <= 2'h0;
			xram_r    <= RST_XRAM_ENABLE;
		end else if (wr_at(sfr_req_i, ADDR_CORE_CONFIGURATION)) begin
			cfg_top_r <= sfr_req_i.wdata[POS_CFG_RESERVED];
			ser_enh_r <= sfr_req_i.wdata[POS_SERIAL_ENH];
			ser_sel_r <= sfr_req_i.wdata[POS_SERIAL_SELECT];
			mod_en_r  <= sfr_req_i.wdata[POS_MOD_ENABLE];
			cfg_rsv_r <= sfr_req_i.wdata[3:2];
			xram_r    <= sfr_req_i.wdata[POS_XRAM_HI:POS_XRAM_LO];
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	// unmapped addresses read as zero; reserved bits read back as stored
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_r <= 8'h00;
		end else if (sfr_req_i.rd) begin
			unique case (sfr_req_i.addr)
				ADDR_STACK_POINTER_LOW:      rdata_r <= spl_r;
				ADDR_DATA_POINTER_LOW:       rdata_r <= dpl_r;
				ADDR_DATA_POINTER_HIGH:      rdata_r <= dph_r;
				ADDR_PROGRAM_CONTROL:        rdata_r <= {double_baud_r, program_control_low_r};
				ADDR_CORE_CONFIGURATION:     rdata_r <= {cfg_top_r, ser_enh_r, ser_sel_r, mod_en_r, cfg_rsv_r, xram_r};
				ADDR_STACK_POINTER_HIGH:     rdata_r <= {sph_top_r, bottom_flag_r, ssa_r, sph_r};
				ADDR_STACK_BOUNDARY_CONTROL: rdata_r <= {waterline_r, viol_reset_r, protect_r, wtrl_flag_r};
				default:                     rdata_r <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata_o = rdata_r;
	// hit tells the core's bus decode that this bank owns the address
	assign sfr_hit_o   = is_mapped(sfr_req_i.addr) && (sfr_req_i.rd || sfr_req_i.wr);

	// ************************************************************
	// violation response and steering outputs
	// ************************************************************
	// interrupt path goes straight to the watchdog vector, ignoring global enable
	// both pulses are combinational and last one cycle per event
	assign stack_irq_o   = (bottom_viol || wtrl_event) && !viol_reset_r;
	assign stack_reset_o = (bottom_viol || wtrl_event) && viol_reset_r;

	assign ctrl_o.double_baud_select        = double_baud_r;
	assign ctrl_o.serial_enhancement_enable = ser_enh_r;
	assign ctrl_o.shared_serial_port_select = ser_sel_r;
	assign ctrl_o.modulation_enable         = mod_en_r;
	// either of the two stored enable bits opens external moves
	assign ctrl_o.external_move_enable      = |xram_r;
	assign ctrl_o.data_pointer_full         = {dph_r, dpl_r};
	assign ctrl_o.stack_pointer             = sp_full;

	// program counter and opcode live apart: neither is reachable over the sfr bus
	csb_pc_unit u_pc (
		.clk_i             (clk_i),
		.srst_i            (srst_i),
		.instr_i           (instr_i),
		.program_counter_o (program_counter_o),
		.opcode_o          (opcode_o)
	);

endmodule : csb_sfr_bank

/* verification/csb_sfr_bank_props.sv */
/*
 * csb_sfr_bank_props: concurrent checks on the core sfr bank ports.
 * assumes: bound to csb_sfr_bank; one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module csb_sfr_bank_props
	import csb_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire csb_sfr_req_s sfr_req_i,
	input  wire logic         stack_push_i,
	input  wire csb_instr_s   instr_i,
	input  wire logic [7:0]   sfr_rdata_o,
	input  wire csb_ctrl_s    ctrl_o,
	input  wire logic         stack_irq_o,
	input  wire logic         stack_reset_o,
	input  wire logic [15:0]  program_counter_o,
	input  wire logic [7:0]   opcode_o
);
	// ************************************************************
	// shadow of the boundary settings, rebuilt from the write stream
	// ************************************************************
	logic [1:0] resp_r;
	logic [2:0] start_r;

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	always_ff @(posedge clk_i) begin
		if (srst_i)
			resp_r <= 2'b00;
		else if (sfr_req_i.wr && sfr_req_i.addr == ADDR_STACK_BOUNDARY_CONTROL)
			resp_r <= sfr_req_i.wdata[2:1];
	end

	always_ff @(posedge clk_i) begin
		if (srst_i)
			start_r <= RST_STACK_START;
		else if (sfr_req_i.wr && sfr_req_i.addr == ADDR_STACK_POINTER_HIGH)
			start_r <= sfr_req_i.wdata[5:3];
	end

	// ************************************************************
	// properties
	// ************************************************************
	sequence s_rd(logic [7:0] a);
		sfr_req_i.rd && !sfr_req_i.wr && sfr_req_i.addr == a;
	endsequence

	sequence s_low_high_write;
		sfr_req_i.wr && sfr_req_i.addr == ADDR_STACK_POINTER_HIGH && resp_r[0]
			&& {sfr_req_i.wdata[2:0], ctrl_o.stack_pointer[7:0]} < {start_r, 8'h00};
	endsequence

	a_read_sp_low: assert property (s_rd(ADDR_STACK_POINTER_LOW) |=>
		sfr_rdata_o == $past(ctrl_o.stack_pointer[7:0])) else $error("stack low read mismatch");
	a_read_dp_high: assert property (s_rd(ADDR_DATA_POINTER_HIGH) |=>
		sfr_rdata_o == $past(ctrl_o.data_pointer_full[15:8])) else $error("data pointer high read mismatch");
	a_xram_either_bit: assert property (s_rd(ADDR_CORE_CONFIGURATION) |=>
		(sfr_rdata_o[1:0] != 2'b00) == $past(ctrl_o.external_move_enable)) else $error("xram enable mismatch");
	a_pc_reset_zero: assert property ($fell(srst_i) |->
		program_counter_o == 16'h0000 && opcode_o == 8'h00) else $error("pc or opcode not zero after reset");
	a_pc_len_step: assert property (instr_i.load && !instr_i.jump |=>
		program_counter_o == $past(program_counter_o) + {14'h0000, $past(instr_i.len)}) else $error("pc step wrong");
	a_pc_jump_load: assert property (instr_i.load && instr_i.jump |=>
		program_counter_o == $past(instr_i.target) && opcode_o == $past(instr_i.opcode)) else $error("jump load wrong");
	a_push_step: assert property (stack_push_i && !sfr_req_i.wr && ctrl_o.stack_pointer != 11'h7ff |=>
		ctrl_o.stack_pointer == $past(ctrl_o.stack_pointer) + 11'h001) else $error("push step wrong");
	a_resp_irq_mode: assert property (stack_irq_o |-> resp_r == 2'b01) else $error("irq in wrong mode");
	a_resp_rst_mode: assert property (stack_reset_o |-> resp_r == 2'b11) else $error("reset in wrong mode");
	a_bottom_drop: assert property (s_low_high_write |-> (stack_irq_o || stack_reset_o)
		##1 $stable(ctrl_o.stack_pointer)) else $error("low pointer write not dropped");
endmodule : csb_sfr_bank_props

bind csb_sfr_bank csb_sfr_bank_props csb_sfr_bank_props_inst (
	.clk_i(clk_i), .srst_i(srst_i), .sfr_req_i(sfr_req_i), .stack_push_i(stack_push_i), .instr_i(instr_i),
	.sfr_rdata_o(sfr_rdata_o), .ctrl_o(ctrl_o), .stack_irq_o(stack_irq_o), .stack_reset_o(stack_reset_o),
	.program_counter_o(program_counter_o), .opcode_o(opcode_o)
);

/* verification/csb_core_model.sv */
/*
 * csb_core_model: processor core side of the sfr bus, one request at a time.
 * assumes: a 1-cycle wr or rd strobe; read data one cycle after the rd edge.
 */
`timescale 1ns/1ps
module csb_core_model
	import csb_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       hit_i,
	output csb_sfr_req_s    req_o
);
	initial req_o = '0;

	// software habits: reserved bits always written with their required values
	function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
		case (a)
			ADDR_PROGRAM_CONTROL:    legal = d & 8'h80;
			ADDR_STACK_POINTER_HIGH: legal = d | 8'h80;
			ADDR_CORE_CONFIGURATION: legal = (d | 8'h80) & 8'hf3;
			default:                 legal = d;
		endcase
	endfunction : legal

	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: legal(a, d)};
		@(posedge clk_i);
		req_o <= '0;
		// let the write land before the caller looks at the outputs
		@(posedge clk_i);
	endtask : sfr_write

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		h = hit_i;
		req_o <= '0;
		@(posedge clk_i);
		d = rdata_i;
	endtask : sfr_read
endmodule : csb_core_model

/* verification/csb_sfr_bank_tb_top.sv */
/*
 * csb_sfr_bank_tb_top: self-checking bench for the core sfr bank.
 * assumes: csb_core_model drives the sfr bus; the bench drives push, data pointer and instruction inputs.
 */
`timescale 1ns/1ps
module csb_sfr_bank_tb_top;
	import csb_pkg::*;
	typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [7:0] m;} csb_row_s;

	logic         clk_i, srst_i, push, pop, dload, irq, rst, hit, h;
	logic [15:0]  dval, pc;
	logic [7:0]   rdata, op, d;
	csb_sfr_req_s req;
	csb_instr_s   ins;
	csb_ctrl_s    ctrl;
	int           num_errors, check_count, irq_cnt, rst_cnt, cycles, c0;
	logic [15:0]  epc;
	// flag bit of the boundary register is unknown at power-up, so it is masked
	csb_row_s rows [14] = '{'{8'h81,0,0,8'h00,8'hff}, '{8'h82,0,0,8'h00,8'hff}, '{8'h83,0,0,8'h00,8'hff},
		'{8'h87,0,0,8'h00,8'hff}, '{8'haf,0,0,8'h81,8'hff}, '{8'hb7,0,0,8'h89,8'hff}, '{8'hbf,0,0,8'h00,8'hfe},
		'{8'h90,0,0,8'h00,8'hff}, '{8'h87,1,8'h80,8'h80,8'hff}, '{8'h82,1,8'h34,8'h34,8'hff},
		'{8'h83,1,8'h12,8'h12,8'hff}, '{8'haf,1,8'hf1,8'hf1,8'hff}, '{8'hb7,1,8'h8a,8'h8a,8'hff},
		'{8'h81,1,8'h55,8'h55,8'hff}};

	csb_core_model csb_core_model_inst (.clk_i(clk_i), .rdata_i(rdata), .hit_i(hit), .req_o(req));
	csb_sfr_bank csb_sfr_bank_inst (.clk_i(clk_i), .srst_i(srst_i), .sfr_req_i(req), .stack_push_i(push),
		.stack_pop_i(pop), .data_pointer_full_load_i(dload), .data_pointer_full_value_i(dval), .instr_i(ins), .sfr_rdata_o(rdata),
		.sfr_hit_o(hit), .ctrl_o(ctrl), .stack_irq_o(irq), .stack_reset_o(rst), .program_counter_o(pc),
		.opcode_o(op));

	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		irq_cnt += irq;
		rst_cnt += rst;
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			results();
		end
	end

	task automatic cmp_val(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_val

	task automatic cmp_cnt(input string n, input int e, input int g);
		check_count++;
		if (g != e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
		end
	endtask : cmp_cnt

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		csb_core_model_inst.sfr_read(a, d, h);
		cmp_val(n, e, d);
	endtask : rd

	task automatic do_reset();
		srst_i <= 1;
		repeat (3) @(posedge clk_i);
		srst_i <= 0;
		@(posedge clk_i);
	endtask : do_reset

	task automatic step(input logic [1:0] l, input logic j, input logic [15:0] t, input logic [7:0] o);
		@(posedge clk_i);
		ins <= '{load: 1'b1, len: l, jump: j, target: t, opcode: o};
		@(posedge clk_i);
		ins.load <= 1'b0;
		@(posedge clk_i);
	endtask : step

	task automatic pop_once();
		@(posedge clk_i);
		pop <= 1'b1;
		@(posedge clk_i);
		pop <= 1'b0;
		@(posedge clk_i);
	endtask : pop_once

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	initial begin
		srst_i = 1; push = 0; pop = 0; dload = 0; dval = 16'h0000; ins = '0;
		do_reset();
		foreach (rows[i]) begin
			if (rows[i].w)
				csb_core_model_inst.sfr_write(rows[i].a, rows[i].d);
			csb_core_model_inst.sfr_read(rows[i].a, d, h);
			cmp_val("sfr read", rows[i].e, d & rows[i].m);
			cmp_val("hit", rows[i].a != 8'h90, h);
		end
		cmp_val("data pointer", 16'h1234, ctrl.data_pointer_full);
		cmp_val("stack pointer", 16'h0255, ctrl.stack_pointer);
		cmp_val("modes", 5'h1f, {ctrl.double_baud_select, ctrl.serial_enhancement_enable,
			ctrl.shared_serial_port_select, ctrl.modulation_enable, ctrl.external_move_enable});
		for (int i = 0; i < 4; i++) begin
			csb_core_model_inst.sfr_write(ADDR_CORE_CONFIGURATION, 8'h80 | 8'(i));
			cmp_val("xram enable", i != 0, ctrl.external_move_enable);
		end
		$display("test registers done");
		cmp_val("pc", 16'h0000, pc);
		epc = 16'h0000;
		for (int i = 1; i < 4; i++) begin
			step(2'(i), 1'b0, 16'h0000, 8'(8'h10 + i));
			epc += 16'(i);
			cmp_val("pc", epc, pc);
			cmp_val("opcode", 8'h10 + 8'(i), op);
		end
		step(2'd3, 1'b1, 16'habcd, 8'h02);
		cmp_val("pc", 16'habcd, pc);
		$display("test program counter done");
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_HIGH, 8'h8f);
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_LOW, 8'hfe);
		csb_core_model_inst.sfr_write(ADDR_STACK_BOUNDARY_CONTROL, 8'h0a);
		c0 = irq_cnt;
		@(posedge clk_i);
		push <= 1;
		@(posedge clk_i);
		push <= 0;
		repeat (2) @(posedge clk_i);
		cmp_cnt("waterline irq", c0 + 1, irq_cnt);
		rd(ADDR_STACK_BOUNDARY_CONTROL, 8'h0b, "flag set");
		csb_core_model_inst.sfr_write(ADDR_STACK_BOUNDARY_CONTROL, 8'h0a);
		rd(ADDR_STACK_BOUNDARY_CONTROL, 8'h0b, "flag kept above line");
		do_reset();
		cmp_val("pc", 16'h0000, pc);
		rd(ADDR_STACK_BOUNDARY_CONTROL, 8'h01, "flag survives reset");
		rd(ADDR_STACK_POINTER_HIGH, 8'h89, "stack high reset");
		csb_core_model_inst.sfr_write(ADDR_STACK_BOUNDARY_CONTROL, 8'h00);
		rd(ADDR_STACK_BOUNDARY_CONTROL, 8'h00, "flag cleared");
		$display("test waterline done");
		csb_core_model_inst.sfr_write(ADDR_STACK_BOUNDARY_CONTROL, 8'h06);
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_HIGH, 8'h92);
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_LOW, 8'h10);
		c0 = rst_cnt;
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_HIGH, 8'h91);
		cmp_cnt("bottom reset", c0 + 1, rst_cnt);
		cmp_val("pointer kept", 16'h0210, ctrl.stack_pointer);
		rd(ADDR_STACK_POINTER_HIGH, 8'hd2, "bottom flag");
		pop_once();
		cmp_val("pop step", 16'h020f, ctrl.stack_pointer);
		csb_core_model_inst.sfr_write(ADDR_STACK_POINTER_LOW, 8'h00);
		c0 = rst_cnt;
		pop_once();
		cmp_cnt("pop below start", c0 + 1, rst_cnt);
		cmp_val("pop dropped", 16'h0200, ctrl.stack_pointer);
		$display("test stack bottom done");
		@(posedge clk_i);
		dload <= 1;
		dval <= 16'hbeef;
		@(posedge clk_i);
		dload <= 0;
		@(posedge clk_i);
		cmp_val("data pointer load", 16'hbeef, ctrl.data_pointer_full);
		$display("test data pointer done");
		results();
	end
endmodule : csb_sfr_bank_tb_top
